// ===== uifc_pkg.sv
// Purpose: constants for the uart interrupt and fifo control block
// Assumes: byte addresses on a 32-bit address port, 16-bit register data
// Notes: fifo-relative thresholds are derived from the fifo depth parameter
package uifc_pkg;

    // register byte addresses
    localparam logic [31:0] OFF_IRQ_EN_DIV_HIGH = 32'h5000_1004;
    localparam logic [31:0] OFF_IRQ_ID_FIFO_CTRL = 32'h5000_1008;
    localparam logic [31:0] OFF_LINE_CTRL = 32'h5000_100C;
    localparam logic [31:0] OFF_MODEM_CTRL = 32'h5000_1010;

    // interrupt enable fields
    localparam int unsigned IEN_PTX_MODE_BIT = 7;
    localparam int unsigned IEN_MODEM_BIT = 3;
    localparam int unsigned IEN_LINE_BIT = 2;
    localparam int unsigned IEN_TXE_BIT = 1;
    localparam int unsigned IEN_RXD_BIT = 0;
    localparam logic [7:0] IEN_WR_MASK = 8'h8F;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;

    // fifo control fields
    localparam int unsigned FC_RX_TRIG_LSB = 6;
    localparam int unsigned FC_TX_THR_LSB = 4;
    localparam int unsigned FC_DMA_MODE_BIT = 3;
    localparam int unsigned FC_TX_RESET_BIT = 2;
    localparam int unsigned FC_RX_RESET_BIT = 1;
    localparam int unsigned FC_ENABLE_BIT = 0;
    localparam logic [1:0] FC_SEL_RST = 2'h0;

    // identification fields
    localparam int unsigned ID_FIFOS_LSB = 6;
    localparam logic [3:0] ID_MODEM = 4'h0;
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_TX_EMPTY = 4'h2;
    localparam logic [3:0] ID_RX_DATA = 4'h4;
    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_BUSY = 4'h7;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;

    // line and modem control fields
    localparam int unsigned LC_DIV_SEL_BIT = 7;
    localparam int unsigned MC_AFC_BIT = 5;
    localparam int unsigned MC_RTS_BIT = 1;
    localparam logic [15:0] READ_ZERO = 16'h0000;

endpackage

// ===== uifc_ctrl.sv
// Purpose: interrupt enable, identification and fifo control of a uart
// Assumes: status inputs come from uart logic on clk_sys_i, no sync needed
// Notes: read data stand one cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
module uifc_ctrl #(
    parameter int unsigned FIFO_DEPTH = 16,
    parameter int unsigned LVL_W = 5
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic line_status_evt_i,
    input wire logic char_timeout_i,
    input wire logic modem_status_evt_i,
    input wire logic busy_detect_i,
    input wire logic [LVL_W-1:0] rx_level_i,
    input wire logic [LVL_W-1:0] tx_level_i,
    output logic irq_o,
    output logic rts_n_o,
    output logic dma_tx_req_n_o,
    output logic dma_rx_req_n_o,
    output logic fifo_enable_o,
    output logic tx_fifo_reset_o,
    output logic rx_fifo_reset_o,
    output logic dma_signal_mode_o,
    output logic prog_tx_empty_irq_mode_en_o,
    output logic divisor_latch_select_o,
    output logic [7:0] baud_divisor_high_o
);

    if (FIFO_DEPTH < 8 || (FIFO_DEPTH % 4) != 0) begin : g_depth_chk
        $error("fifo depth must be a multiple of four, eight or more");
    end
    if (LVL_W != $clog2(FIFO_DEPTH + 1)) begin : g_width_chk
        $error("level width must hold the full fifo depth");
    end

    // rx trigger: 1, quarter, half, two short of full
    function automatic logic [LVL_W-1:0] rx_trig(input logic [1:0] sel);
        logic [LVL_W-1:0] t;
        t = LVL_W'(1);
        unique case (sel)
            2'h0: t = LVL_W'(1);
            2'h1: t = LVL_W'(FIFO_DEPTH / 4);
            2'h2: t = LVL_W'(FIFO_DEPTH / 2);
            2'h3: t = LVL_W'(FIFO_DEPTH - 2);
        endcase
        return t;
    endfunction

    // tx threshold: empty, two, quarter, half
    function automatic logic [LVL_W-1:0] tx_thr(input logic [1:0] sel);
        logic [LVL_W-1:0] t;
        t = LVL_W'(0);
        unique case (sel)
            2'h0: t = LVL_W'(0);
            2'h1: t = LVL_W'(2);
            2'h2: t = LVL_W'(FIFO_DEPTH / 4);
            2'h3: t = LVL_W'(FIFO_DEPTH / 2);
        endcase
        return t;
    endfunction

    logic [7:0] irq_en_q;
    logic [7:0] div_high_q;
    logic div_sel_q;
    logic afc_q;
    logic rts_req_q;
    logic fifo_en_q;
    logic dma_mode_q;
    logic [1:0] tx_thr_sel_q;
    logic [1:0] rx_trig_sel_q;
    logic tx_rst_q;
    logic rx_rst_q;
    logic [15:0] rdata_q;
    logic irq_q;
    logic rts_n_q;
    logic dma_tx_act_q;
    logic dma_rx_act_q;

    // address decode
    wire sel_en_div = (addr_i == uifc_pkg::OFF_IRQ_EN_DIV_HIGH);
    wire sel_id_fc = (addr_i == uifc_pkg::OFF_IRQ_ID_FIFO_CTRL);
    wire sel_line = (addr_i == uifc_pkg::OFF_LINE_CTRL);
    wire sel_modem = (addr_i == uifc_pkg::OFF_MODEM_CTRL);
    wire wr_irq_en = wr_i & sel_en_div & ~div_sel_q;
    wire wr_div_high = wr_i & sel_en_div & div_sel_q;
    wire wr_fifo_ctrl = wr_i & sel_id_fc;
    wire wr_line = wr_i & sel_line;
    wire wr_modem = wr_i & sel_modem;

    // write data fields
    wire new_fifo_en = wdata_i[uifc_pkg::FC_ENABLE_BIT];
    wire fifo_en_flip = wr_fifo_ctrl & (new_fifo_en != fifo_en_q);
    // toggling fifo enable also flushes both fifos, stale data is meaningless
    wire tx_rst_d = (wr_fifo_ctrl & wdata_i[uifc_pkg::FC_TX_RESET_BIT])
        | fifo_en_flip;
    wire rx_rst_d = (wr_fifo_ctrl & wdata_i[uifc_pkg::FC_RX_RESET_BIT])
        | fifo_en_flip;

    // interrupt sources
    wire ptx_mode = irq_en_q[uifc_pkg::IEN_PTX_MODE_BIT];
    wire [LVL_W-1:0] rx_trig_lvl = rx_trig(rx_trig_sel_q);
    wire [LVL_W-1:0] tx_thr_lvl = tx_thr(tx_thr_sel_q);
    wire rx_empty = (rx_level_i == LVL_W'(0));
    wire tx_empty = (tx_level_i == LVL_W'(0));
    wire tx_full = (tx_level_i == LVL_W'(FIFO_DEPTH));
    wire rx_at_trig = (rx_level_i >= rx_trig_lvl);
    wire tx_at_thr = (tx_level_i <= tx_thr_lvl);
    // without fifos a single held character counts as available
    wire rx_avail = fifo_en_q ? rx_at_trig : ~rx_empty;
    // programmable mode only makes sense with fifos on
    wire txe_cond = (ptx_mode & fifo_en_q) ? tx_at_thr : tx_empty;
    wire src_line = irq_en_q[uifc_pkg::IEN_LINE_BIT]
        & line_status_evt_i;
    wire src_rxd = irq_en_q[uifc_pkg::IEN_RXD_BIT] & rx_avail;
    wire src_tmo = irq_en_q[uifc_pkg::IEN_RXD_BIT] & fifo_en_q
        & char_timeout_i;
    wire src_txe = irq_en_q[uifc_pkg::IEN_TXE_BIT] & txe_cond;
    wire src_modem = irq_en_q[uifc_pkg::IEN_MODEM_BIT]
        & modem_status_evt_i;

    // priority chain, line status first, busy detect last
    wire [3:0] pending_irq_code =
        src_line ? uifc_pkg::ID_LINE :
        src_rxd ? uifc_pkg::ID_RX_DATA :
        src_tmo ? uifc_pkg::ID_TIMEOUT :
        src_txe ? uifc_pkg::ID_TX_EMPTY :
        src_modem ? uifc_pkg::ID_MODEM :
        busy_detect_i ? uifc_pkg::ID_BUSY :
        uifc_pkg::ID_NONE;

    wire [1:0] fifos_enabled_status = {2{fifo_en_q}};
    wire [15:0] irq_identification = {8'h00, fifos_enabled_status,
        2'h0, pending_irq_code};

    // dma request levels
    wire dma_rx_d = dma_mode_q
        ? ((rx_avail | (fifo_en_q & char_timeout_i))
           | (dma_rx_act_q & ~rx_empty))
        : ~rx_empty;
    // mode 1 holds the tx request until the fifo is full
    wire dma_tx_d = dma_mode_q
        ? (txe_cond | (dma_tx_act_q & ~tx_full))
        : tx_empty;
    // auto flow only runs with fifos enabled
    wire rts_n_d = ~rts_req_q
        | (afc_q & fifo_en_q & rx_at_trig);

    // read mux
    wire [15:0] rd_en_div = div_sel_q ? {8'h00, div_high_q}
        : {8'h00, irq_en_q};
    wire [15:0] rd_line = 16'(div_sel_q) << uifc_pkg::LC_DIV_SEL_BIT;
    wire [15:0] rd_modem = (16'(afc_q) << uifc_pkg::MC_AFC_BIT)
        | (16'(rts_req_q) << uifc_pkg::MC_RTS_BIT);
    wire [15:0] rd_mux = sel_en_div ? rd_en_div :
        sel_id_fc ? irq_identification :
        sel_line ? rd_line :
        sel_modem ? rd_modem :
        uifc_pkg::READ_ZERO;
    wire [15:0] rdata_d = rd_i ? rd_mux : uifc_pkg::READ_ZERO;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en_q <= uifc_pkg::IEN_RST;
            div_high_q <= uifc_pkg::DIV_HIGH_RST;
        end else begin
            if (wr_irq_en) begin
                irq_en_q <= wdata_i[7:0] & uifc_pkg::IEN_WR_MASK;
            end
            if (wr_div_high) begin
                div_high_q <= wdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_sel_q <= 1'b0;
            afc_q <= 1'b0;
            rts_req_q <= 1'b0;
        end else begin
            if (wr_line) begin
                div_sel_q <= wdata_i[uifc_pkg::LC_DIV_SEL_BIT];
            end
            if (wr_modem) begin
                afc_q <= wdata_i[uifc_pkg::MC_AFC_BIT];
                rts_req_q <= wdata_i[uifc_pkg::MC_RTS_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fifo_en_q <= 1'b0;
            dma_mode_q <= 1'b0;
            tx_thr_sel_q <= uifc_pkg::FC_SEL_RST;
            rx_trig_sel_q <= uifc_pkg::FC_SEL_RST;
        end else if (wr_fifo_ctrl) begin
            fifo_en_q <= new_fifo_en;
            dma_mode_q <= wdata_i[uifc_pkg::FC_DMA_MODE_BIT];
            tx_thr_sel_q <= wdata_i[uifc_pkg::FC_TX_THR_LSB +: 2];
            rx_trig_sel_q <= wdata_i[uifc_pkg::FC_RX_TRIG_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_rst_q <= 1'b0;
            rx_rst_q <= 1'b0;
            rdata_q <= uifc_pkg::READ_ZERO;
            irq_q <= 1'b0;
            rts_n_q <= 1'b1;
            dma_tx_act_q <= 1'b0;
            dma_rx_act_q <= 1'b0;
        end else begin
            tx_rst_q <= tx_rst_d;
            rx_rst_q <= rx_rst_d;
            rdata_q <= rdata_d;
            irq_q <= (pending_irq_code != uifc_pkg::ID_NONE);
            rts_n_q <= rts_n_d;
            dma_tx_act_q <= dma_tx_d;
            dma_rx_act_q <= dma_rx_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign rts_n_o = rts_n_q;
    assign dma_tx_req_n_o = ~dma_tx_act_q;
    assign dma_rx_req_n_o = ~dma_rx_act_q;
    assign fifo_enable_o = fifo_en_q;
    assign tx_fifo_reset_o = tx_rst_q;
    assign rx_fifo_reset_o = rx_rst_q;
    assign dma_signal_mode_o = dma_mode_q;
    assign prog_tx_empty_irq_mode_en_o = ptx_mode;
    assign divisor_latch_select_o = div_sel_q;
    assign baud_divisor_high_o = div_high_q;

    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_id_read;
        rd_i && sel_id_fc;
    endsequence

    sequence s_fifo_on_write;
        wr_fifo_ctrl && new_fifo_en;
    endsequence

    sequence s_tx_reset_write;
        wr_fifo_ctrl && wdata_i[uifc_pkg::FC_TX_RESET_BIT];
    endsequence

    a_irq_when_pending: assert property (
        (pending_irq_code != uifc_pkg::ID_NONE) |=> irq_o)
        else $error("interrupt output low while a source pends");

    a_irq_idle_low: assert property (
        (pending_irq_code == uifc_pkg::ID_NONE) |=> !irq_o)
        else $error("interrupt output high with nothing pending");

    a_line_top_prio: assert property (
        (irq_en_q[uifc_pkg::IEN_LINE_BIT] && line_status_evt_i)
        and s_id_read
        |=> rdata_o[3:0] == uifc_pkg::ID_LINE)
        else $error("line status not reported first");

    a_modem_gated: assert property (
        !irq_en_q[uifc_pkg::IEN_MODEM_BIT]
        |-> pending_irq_code != uifc_pkg::ID_MODEM)
        else $error("modem status reported while disabled");

    a_txe_gated: assert property (
        !irq_en_q[uifc_pkg::IEN_TXE_BIT]
        |-> pending_irq_code != uifc_pkg::ID_TX_EMPTY)
        else $error("tx empty reported while disabled");

    a_rxd_gated: assert property (
        !irq_en_q[uifc_pkg::IEN_RXD_BIT]
        |-> pending_irq_code != uifc_pkg::ID_RX_DATA
            && pending_irq_code != uifc_pkg::ID_TIMEOUT)
        else $error("rx data or timeout reported while disabled");

    a_div_write: assert property (
        (wr_i && sel_en_div && div_sel_q)
        |=> baud_divisor_high_o == $past(wdata_i[7:0])
            && $stable(irq_en_q))
        else $error("divisor high byte write misrouted");

    a_en_write: assert property (
        (wr_i && sel_en_div && !div_sel_q)
        |=> $stable(baud_divisor_high_o))
        else $error("divisor changed by an enable write");

    a_fifos_status: assert property (
        s_fifo_on_write ##1 ((!wr_fifo_ctrl) and s_id_read)
        |=> rdata_o[uifc_pkg::ID_FIFOS_LSB +: 2] == 2'h3)
        else $error("fifo enable status not shown as 11");

    a_tx_reset_pulse: assert property (
        s_tx_reset_write ##1 !wr_fifo_ctrl
        |-> tx_fifo_reset_o ##1 !tx_fifo_reset_o)
        else $error("tx fifo reset not a single pulse");

    a_rts_drop: assert property (
        (afc_q && fifo_en_q && rx_at_trig && !wr_modem && !wr_fifo_ctrl)
        |=> rts_n_o)
        else $error("rts held active at rx trigger level");

    a_dma_rx_mode0: assert property (
        (!dma_mode_q && !rx_empty) |=> !dma_rx_req_n_o)
        else $error("rx dma request missing in mode 0");

    a_dma_tx_mode1_hold: assert property (
        (dma_mode_q && !dma_tx_req_n_o && !tx_full && !wr_fifo_ctrl)
        |=> !dma_tx_req_n_o)
        else $error("tx dma request dropped before full in mode 1");

    a_read_one_cycle: assert property (
        !rd_i |=> rdata_o == uifc_pkg::READ_ZERO)
        else $error("read data stood beyond its cycle");

    a_rx_trig_report: assert property (
        (fifo_en_q && irq_en_q[uifc_pkg::IEN_RXD_BIT] && !src_line
            && rx_level_i >= rx_trig_lvl)
        |-> pending_irq_code == uifc_pkg::ID_RX_DATA)
        else $error("rx data at trigger not reported");

    a_tx_reset_set: assert property (
        s_tx_reset_write |=> tx_fifo_reset_o)
        else $error("tx fifo reset not raised");

    a_rx_reset_set: assert property (
        (wr_fifo_ctrl && wdata_i[uifc_pkg::FC_RX_RESET_BIT])
        |=> rx_fifo_reset_o)
        else $error("rx fifo reset not raised");

    a_fifo_en_load: assert property (
        wr_fifo_ctrl |=> fifo_enable_o == $past(new_fifo_en))
        else $error("fifo enable not loaded");

    a_dma_mode_load: assert property (
        wr_fifo_ctrl
        |=> dma_signal_mode_o
            == $past(wdata_i[uifc_pkg::FC_DMA_MODE_BIT]))
        else $error("dma mode not loaded");

    a_ptx_mode_load: assert property (
        (wr_i && sel_en_div && !div_sel_q)
        |=> prog_tx_empty_irq_mode_en_o
            == $past(wdata_i[uifc_pkg::IEN_PTX_MODE_BIT]))
        else $error("tx empty mode bit not loaded");

    a_div_sel_load: assert property (
        wr_line
        |=> divisor_latch_select_o
            == $past(wdata_i[uifc_pkg::LC_DIV_SEL_BIT]))
        else $error("divisor select not loaded");

    a_fifos_off_status: assert property (
        (!fifo_en_q) and s_id_read
        |=> rdata_o[uifc_pkg::ID_FIFOS_LSB +: 2] == 2'h0)
        else $error("fifo status not 00 while disabled");

endmodule

// ===== uifc_peer_model.sv
// Purpose: fifo and line side model feeding status into uifc_ctrl
// Assumes: bench loads levels and events with a one-cycle load strobe
// Notes: fifo reset pulses empty the modelled fifos as the core would
`timescale 1ns/1ps
module uifc_peer_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [3:0] evt_set_i,
    input wire logic [4:0] rx_set_i,
    input wire logic [4:0] tx_set_i,
    input wire logic tx_fifo_reset_i,
    input wire logic rx_fifo_reset_i,
    output logic line_status_evt_o,
    output logic char_timeout_o,
    output logic modem_status_evt_o,
    output logic busy_detect_o,
    output logic [4:0] rx_level_o,
    output logic [4:0] tx_level_o
);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_status_evt_o <= 1'b0;
            char_timeout_o <= 1'b0;
            modem_status_evt_o <= 1'b0;
            busy_detect_o <= 1'b0;
            rx_level_o <= 5'h00;
            tx_level_o <= 5'h00;
        end else begin
            if (load_i) begin
                line_status_evt_o <= evt_set_i[3];
                char_timeout_o <= evt_set_i[2];
                modem_status_evt_o <= evt_set_i[1];
                busy_detect_o <= evt_set_i[0];
                rx_level_o <= rx_set_i;
                tx_level_o <= tx_set_i;
            end
            // a reset pulse wins over a load in the same cycle
            if (tx_fifo_reset_i) begin
                tx_level_o <= 5'h00;
            end
            if (rx_fifo_reset_i) begin
                rx_level_o <= 5'h00;
            end
        end
    end
endmodule

// ===== uifc_ctrl_tb.sv
// Purpose: self-checking bench for uifc_ctrl over its register port
// Assumes: fifo depth 16, status comes from uifc_peer_model
// Notes: status needs two edges after the load strobe to reach irq, st() waits three
`timescale 1ns/1ps
module uifc_ctrl_tb;
    localparam logic [31:0] A_IEN = uifc_pkg::OFF_IRQ_EN_DIV_HIGH;
    localparam logic [31:0] A_ID = uifc_pkg::OFF_IRQ_ID_FIFO_CTRL;
    localparam logic [31:0] A_LC = uifc_pkg::OFF_LINE_CTRL;
    localparam logic [31:0] A_MC = uifc_pkg::OFF_MODEM_CTRL;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [31:0] addr_i = 32'h0000_0000;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic load = 1'b0;
    logic [3:0] evt_set = 4'h0;
    logic [4:0] rx_set = 5'h00;
    logic [4:0] tx_set = 5'h00;
    logic [15:0] rdata_o;
    logic irq_o, rts_n_o, dtx_n, drx_n, fe, txr, rxr, dma_signal_mode, ptx, dsel;
    logic lse, cto, mse, bsy;
    logic [7:0] divh;
    logic [4:0] rxl, txl;
    logic [15:0] rv;
    int err_count = 0;
    int tests_run = 0;
    // rows: ier, events {line,timeout,modem,busy}, rx, tx, code
    logic [7:0] ier_t [8] = '{8'h0F, 8'h0B, 8'h0A, 8'h08,
        8'h00, 8'h00, 8'h0F, 8'h0F};
    logic [3:0] ev_t [8] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hE, 4'h7, 4'h3};
    logic [4:0] rx_t [8] = '{5'h01, 5'h01, 5'h01, 5'h01,
        5'h01, 5'h01, 5'h00, 5'h00};
    logic [4:0] tx_t [8] = '{5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h03, 5'h03};
    logic [3:0] code_t [8] = '{4'h6, 4'h4, 4'h2, 4'h0, 4'h7, 4'h1, 4'hC, 4'h0};
    logic [4:0] trg [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    logic [4:0] thr [4] = '{5'h00, 5'h02, 5'h04, 5'h08};

    always #2 clk_sys_i = ~clk_sys_i;

    uifc_ctrl #(.FIFO_DEPTH(16), .LVL_W(5)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .line_status_evt_i(lse), .char_timeout_i(cto),
        .modem_status_evt_i(mse), .busy_detect_i(bsy),
        .rx_level_i(rxl), .tx_level_i(txl), .irq_o(irq_o),
        .rts_n_o(rts_n_o), .dma_tx_req_n_o(dtx_n), .dma_rx_req_n_o(drx_n),
        .fifo_enable_o(fe), .tx_fifo_reset_o(txr), .rx_fifo_reset_o(rxr),
        .dma_signal_mode_o(dma_signal_mode), .prog_tx_empty_irq_mode_en_o(ptx),
        .divisor_latch_select_o(dsel), .baud_divisor_high_o(divh));

    uifc_peer_model peer_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .load_i(load),
        .evt_set_i(evt_set), .rx_set_i(rx_set), .tx_set_i(tx_set),
        .tx_fifo_reset_i(txr), .rx_fifo_reset_i(rxr),
        .line_status_evt_o(lse), .char_timeout_o(cto),
        .modem_status_evt_o(mse), .busy_detect_o(bsy),
        .rx_level_o(rxl), .tx_level_o(txl));

    task automatic chk(input string name, input logic [15:0] e,
        input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", name, e, g);
            err_count++;
        end
    endtask
    task automatic chk1(input string name, input logic e, input logic g);
        chk(name, {15'h0000, e}, {15'h0000, g});
    endtask
    function automatic logic [15:0] idv(input logic f, input logic [3:0] c);
        return {8'h00, f, f, 2'h0, c};
    endfunction
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // write then read with no idle cycle between the strobes
    task automatic wrrd(input logic [31:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        q = rdata_o;
    endtask
    task automatic st(input logic [3:0] e, input logic [4:0] r,
        input logic [4:0] t);
        @(posedge clk_sys_i);
        load <= 1'b1;
        evt_set <= e;
        rx_set <= r;
        tx_set <= t;
        @(posedge clk_sys_i);
        load <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk_sys_i);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(A_IEN, rv);
        chk("ien_rst", 16'h0000, rv);
        rd(A_ID, rv);
        chk("id_rst", idv(1'b0, uifc_pkg::ID_NONE), rv);
        wr(A_IEN, 16'hFFFF);
        rd(A_IEN, rv);
        chk("ien_rw", 16'h008F, rv);
        @(posedge clk_sys_i);
        #1;
        chk("rd_gone", 16'h0000, rdata_o);
        chk1("ptx_mode", 1'b1, ptx);
        wr(A_LC, 16'h0080);
        chk1("div_sel", 1'b1, dsel);
        wr(A_IEN, 16'h00A5);
        chk("div_out", 16'h00A5, {8'h00, divh});
        rd(A_IEN, rv);
        chk("div_rd", 16'h00A5, rv);
        wr(A_LC, 16'h0000);
        rd(A_IEN, rv);
        chk("ien_kept", 16'h008F, rv);
        wr(32'h5000_1014, 16'hFFFF);
        rd(32'h5000_1014, rv);
        chk("unmapped", 16'h0000, rv);
        wrrd(A_ID, 16'h0001, rv);
        chk1("fifo_en", 1'b1, fe);
        chk("id_fifo_on", idv(1'b1, uifc_pkg::ID_TX_EMPTY), rv);
        for (int i = 0; i < 8; i++) begin
            wr(A_IEN, {8'h00, ier_t[i]});
            st(ev_t[i], rx_t[i], tx_t[i]);
            rd(A_ID, rv);
            chk("id_code", idv(1'b1, code_t[i]), rv);
            chk1("irq", code_t[i] != uifc_pkg::ID_NONE, irq_o);
        end
        wr(A_MC, 16'h0022);
        wr(A_IEN, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            wr(A_ID, {8'h00, k[1:0], 6'h01});
            st(4'h0, trg[k] - 5'h01, 5'h00);
            rd(A_ID, rv);
            chk("rx_below", idv(1'b1, uifc_pkg::ID_NONE), rv);
            chk1("rts_on", 1'b0, rts_n_o);
            st(4'h0, trg[k], 5'h00);
            rd(A_ID, rv);
            chk("rx_at", idv(1'b1, uifc_pkg::ID_RX_DATA), rv);
            chk1("rts_off", 1'b1, rts_n_o);
        end
        wr(A_IEN, 16'h0082);
        for (int k = 0; k < 4; k++) begin
            wr(A_ID, {8'h00, 2'h0, k[1:0], 4'h1});
            st(4'h0, 5'h00, thr[k]);
            rd(A_ID, rv);
            chk("tx_at", idv(1'b1, uifc_pkg::ID_TX_EMPTY), rv);
            st(4'h0, 5'h00, thr[k] + 5'h01);
            rd(A_ID, rv);
            chk("tx_above", idv(1'b1, uifc_pkg::ID_NONE), rv);
        end
        st(4'h0, 5'h00, 5'h08);
        wr(A_IEN, 16'h0002);
        rd(A_ID, rv);
        chk("ptx_off", idv(1'b1, uifc_pkg::ID_NONE), rv);
        wr(A_ID, 16'h0081);
        st(4'h0, 5'h01, 5'h00);
        chk1("rx_dma0", 1'b0, drx_n);
        chk1("tx_dma0", 1'b0, dtx_n);
        st(4'h0, 5'h00, 5'h01);
        chk1("rx_dma0_off", 1'b1, drx_n);
        chk1("tx_dma0_off", 1'b1, dtx_n);
        wr(A_ID, 16'h0089);
        chk1("dma_mode", 1'b1, dma_signal_mode);
        st(4'h0, 5'h01, 5'h00);
        chk1("rx_dma1_low", 1'b1, drx_n);
        st(4'h0, 5'h08, 5'h01);
        chk1("rx_dma1_trig", 1'b0, drx_n);
        chk1("tx_dma1_held", 1'b0, dtx_n);
        st(4'h0, 5'h01, 5'h01);
        chk1("rx_dma1_held", 1'b0, drx_n);
        st(4'h0, 5'h00, 5'h01);
        chk1("rx_dma1_empty", 1'b1, drx_n);
        wr(A_ID, 16'h0001);
        st(4'h0, 5'h05, 5'h05);
        wr(A_ID, 16'h0005);
        chk1("txr_pulse", 1'b1, txr);
        chk1("rxr_quiet", 1'b0, rxr);
        @(posedge clk_sys_i);
        #1;
        chk1("txr_self", 1'b0, txr);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk1("tx_emptied", 1'b0, dtx_n);
        chk1("rx_kept", 1'b0, drx_n);
        wr(A_ID, 16'h0003);
        chk1("rxr_pulse", 1'b1, rxr);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk1("rx_emptied", 1'b1, drx_n);
        wr(A_ID, 16'h0000);
        chk1("fifo_off", 1'b0, fe);
        rd(A_ID, rv);
        chk("id_fifo_off", idv(1'b0, uifc_pkg::ID_TX_EMPTY), rv);
        wrap_up();
    end
endmodule
